// [hdl/rcr_map.svh]
// Purpose: timing counts, field positions and reset values of the
//          rolling-code receiver control block
// Assumes: 50 MHz system clock; all timing runs on a 1 ms tick
// Notes:   definitions only, no logic
`ifndef RCR_MAP_SVH
`define RCR_MAP_SVH

// clock and base tick
`define RCR_CLK_HZ 50000000
`define RCR_TICK_US 1000
`define RCR_TICK_CYCLES (`RCR_CLK_HZ / 1000000 * `RCR_TICK_US)

// times in ms, as counts of 1 ms ticks
`define RCR_VALID_PULSE_MS 50
`define RCR_VALID_PULSE_TICKS (`RCR_VALID_PULSE_MS * 1000 / `RCR_TICK_US)
`define RCR_FUNC_MS 530
`define RCR_FUNC_TICKS (`RCR_FUNC_MS * 1000 / `RCR_TICK_US)
`define RCR_LONG_MS 3500
`define RCR_LONG_TICKS (`RCR_LONG_MS * 1000 / `RCR_TICK_US)
`define RCR_GAP_MS 610
`define RCR_GAP_TICKS (`RCR_GAP_MS * 1000 / `RCR_TICK_US)

// slot of the privileged transmitter
`define RCR_PRIV_SLOT 3'h0

// decoded word field positions
`define RCR_SEQ_LSB 0
`define RCR_DISC_LSB 16
`define RCR_BTN_LSB 28

// reset values
`define RCR_LEARN_IDLE 1'b1
`define RCR_FIRST_FREE 3'h1

`endif

// [hdl/rcr_pkg.sv]
// Purpose: types shared by the rolling-code receiver control block
// Assumes: serial number sent in clear, code word scrambled
// Notes:   constants live in rcr_map.svh
package rcr_pkg;

    // one demodulated transmission
    typedef struct packed {
        logic [23:0] serial;  // transmitter identity, sent in clear
        logic [31:0] code;    // scrambled word
    } rcr_frame_t;

    // descrambled word layout
    typedef struct packed {
        logic [3:0] button;   // pressed button bits
        logic [11:0] disc;    // must equal serial[11:0]
        logic [15:0] seq;     // rolling sequence value
    } rcr_word_t;

    // write-only programming of one storage slot
    typedef struct packed {
        logic [2:0] slot;
        logic [23:0] serial;
        logic [63:0] key;
        logic [15:0] hist;
    } rcr_prog_t;

    // operating mode
    typedef enum logic [0:0] {
        RCR_RUN,
        RCR_LEARN
    } rcr_mode_t;

endpackage

// [hdl/rcr_descramble.sv]
// Purpose: keyed nonlinear descrambler for the 32 bit code word
// Assumes: transmitter applies the exact inverse of these rounds
// Notes:   purely combinational; one 16 bit key word per round
`timescale 1ns/10ps
`default_nettype none

module rcr_descramble #(
    parameter int ROUNDS = 8
) (
    input wire logic [63:0] key,
    input wire logic [31:0] code_in,
    output logic [31:0] word_out
);

    // nonlinear round mix: rotate, key add, and/or fold
    function automatic logic [15:0] mix(input logic [15:0] h,
                                        input logic [15:0] k);
        logic [15:0] r;
        r = {h[12:0], h[15:13]} ^ k;
        mix = r ^ {r[7:0] & r[15:8], r[15:8] | r[7:0]};
    endfunction

    // feistel rounds; a feistel net is invertible for any mix
    always_comb begin
        logic [15:0] a;
        logic [15:0] b;
        logic [15:0] t;
        a = code_in[31:16];
        b = code_in[15:0];
        t = '0;
        for (int i = 0; i < ROUNDS; i++) begin
            t = b ^ mix(a, key[16 * (i % 4) +: 16]);
            b = a;
            a = t;
        end
        word_out = {a, b};
    end

endmodule // rcr_descramble

`default_nettype wire

// [hdl/rcr_control.sv]
// Purpose: rolling-code receiver control: validation, outputs, pairing
// Assumes: frames arrive demodulated as one-cycle strobes
// Notes:   key storage is write-only; slot 0 is the privileged one
`timescale 1ns/10ps
`default_nettype none
`include "rcr_map.svh"

module rcr_control #(
    parameter int NUM_SLOTS = 6,
    parameter int TICK_CYCLES = `RCR_TICK_CYCLES,
    // arbitrary seed for pairing key derivation
    parameter logic [63:0] LEARN_SEED = 64'h5A3C_96E1_0F4B_D287
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic frame_stb,
    input wire rcr_pkg::rcr_frame_t frame,
    input wire logic prog_stb,
    input wire rcr_pkg::rcr_prog_t prog,
    input wire logic learn_req_n,
    output logic [2:0] button_function_outputs,
    output logic toggled_function_output,
    output logic long_press_output,
    output logic valid_indicator,
    output logic privileged_output,
    output logic pairing_active
);

    localparam int SW = 3;

    // key storage: writes only, no read port leaves the block
    logic slot_used_reg [NUM_SLOTS];
    logic [23:0] slot_serial_reg [NUM_SLOTS];
    logic [63:0] slot_key_reg [NUM_SLOTS];
    logic [15:0] slot_hist_reg [NUM_SLOTS];  // per-slot history
    logic [SW-1:0] repl_ptr_reg;             // oldest learned slot

    rcr_pkg::rcr_mode_t mode_reg;
    logic learn_prev_reg;   // last sample of the pairing request
    logic pend_reg;         // first good pairing frame seen
    logic bad_reg;          // first bad pairing frame seen
    logic [23:0] pend_serial_reg;
    logic [15:0] pend_seq_reg;

    logic [31:0] tick_cnt_reg;
    logic tick_reg;         // 1 ms enable pulse
    logic [11:0] gap_cnt_reg;
    logic [11:0] hold_cnt_reg;
    logic [11:0] func_cnt_reg;
    logic [11:0] rep_cnt_reg;
    logic [SW-1:0] last_slot_reg;
    logic [3:0] last_btn_reg;

    // sequence is newer if it lies ahead within half the range
    function automatic logic seq_newer(input logic [15:0] s,
                                       input logic [15:0] h);
        logic [15:0] d;
        d = s - h;
        seq_newer = (d != 16'h0000) && !d[15];
    endfunction

    // saturating countdown for the ms timers
    function automatic logic [11:0] cnt_down(input logic [11:0] v);
        cnt_down = (v == 12'h000) ? 12'h000 : v - 12'h001;
    endfunction

    // per-transmitter key for pairing, derived from its serial
    function automatic logic [63:0] learn_key(input logic [23:0] s);
        learn_key = LEARN_SEED ^ {s, s, s[15:0]};
    endfunction

    // lookup of the transmitter by serial
    logic hit;
    logic [SW-1:0] hit_idx;
    always_comb begin
        hit = 1'b0;
        hit_idx = '0;
        for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
            if (slot_used_reg[i] && slot_serial_reg[i] == frame.serial) begin
                hit = 1'b1;
                hit_idx = SW'(i);
            end
        end
    end

    // first free learnable slot; slot 0 is skipped
    logic free_found;
    logic [SW-1:0] free_idx;
    always_comb begin
        free_found = 1'b0;
        free_idx = '0;
        for (int i = NUM_SLOTS - 1; i >= 1; i--) begin
            if (!slot_used_reg[i]) begin
                free_found = 1'b1;
                free_idx = SW'(i);
            end
        end
    end

    wire learning = (mode_reg == rcr_pkg::RCR_LEARN);
    wire hit_priv = hit && (hit_idx == `RCR_PRIV_SLOT);
    // each transmitter's own key, never a shared one
    wire [63:0] key_sel = learning ? learn_key(frame.serial)
                                   : slot_key_reg[hit_idx];
    logic [31:0] word_raw;
    rcr_pkg::rcr_word_t word;

    rcr_descramble u_descramble (
        .key(key_sel),
        .code_in(frame.code),
        .word_out(word_raw)
    );
    assign word = word_raw;

    wire disc_ok = (word.disc == frame.serial[11:0]);
    // accept only paired key and newer sequence
    wire run_ok = !learning && hit && disc_ok
                  && seq_newer(word.seq, slot_hist_reg[hit_idx]);
    wire accept = frame_stb && run_ok;
    // pairing candidate: never the privileged one, sequence must advance
    wire pend_match = (frame.serial == pend_serial_reg)
                      && seq_newer(word.seq, pend_seq_reg);
    wire learn_ok = learning && !hit_priv && disc_ok
                    && (!pend_reg || pend_match);
    wire learn_done = frame_stb && learn_ok && pend_reg;
    // relearn an existing slot, else free slot, else oldest
    wire reuse = hit && !hit_priv;
    wire [SW-1:0] target = reuse ? hit_idx
                         : (free_found ? free_idx : repl_ptr_reg);
    wire [SW-1:0] ptr_wrap = (repl_ptr_reg == SW'(NUM_SLOTS - 1))
                             ? `RCR_FIRST_FREE : repl_ptr_reg + 3'h1;
    // momentary low then release on the pairing request
    wire learn_release = !learn_prev_reg && learn_req_n;
    wire receiving = (gap_cnt_reg != 12'h000);
    wire same_press = receiving && (last_slot_reg == hit_idx)
                      && (last_btn_reg == word.button);

    // storage writes; the programming port wins a same-cycle clash
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_SLOTS; i++) begin
                slot_used_reg[i] <= 1'b0;
                slot_serial_reg[i] <= 24'h000000;
                slot_key_reg[i] <= 64'h0;
                slot_hist_reg[i] <= 16'h0000;
            end
            repl_ptr_reg <= `RCR_FIRST_FREE;
        end else if (prog_stb) begin
            // direct programming, the only path into slot 0
            slot_used_reg[prog.slot] <= 1'b1;
            slot_serial_reg[prog.slot] <= prog.serial;
            slot_key_reg[prog.slot] <= prog.key;
            slot_hist_reg[prog.slot] <= prog.hist;
        end else if (accept) begin
            slot_hist_reg[hit_idx] <= word.seq;
        end else if (learn_done) begin
            slot_used_reg[target] <= 1'b1;
            slot_serial_reg[target] <= frame.serial;
            slot_key_reg[target] <= learn_key(frame.serial);
            slot_hist_reg[target] <= word.seq;
            if (!reuse && !free_found) begin
                repl_ptr_reg <= ptr_wrap;
            end
        end
    end

    // pairing mode state machine
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= rcr_pkg::RCR_RUN;
            learn_prev_reg <= `RCR_LEARN_IDLE;
            pend_reg <= 1'b0;
            bad_reg <= 1'b0;
            pend_serial_reg <= 24'h000000;
            pend_seq_reg <= 16'h0000;
            pairing_active <= 1'b0;
        end else begin
            learn_prev_reg <= learn_req_n;
            case (mode_reg)
                rcr_pkg::RCR_RUN: begin
                    // covers both entry procedures
                    if (learn_release) begin
                        mode_reg <= rcr_pkg::RCR_LEARN;
                        pairing_active <= 1'b1;
                        pend_reg <= 1'b0;
                        bad_reg <= 1'b0;
                    end
                end
                rcr_pkg::RCR_LEARN: begin
                    if (frame_stb && learn_ok && !pend_reg) begin
                        pend_reg <= 1'b1;
                        pend_serial_reg <= frame.serial;
                        pend_seq_reg <= word.seq;
                    end else if (learn_done) begin
                        mode_reg <= rcr_pkg::RCR_RUN;
                        pairing_active <= 1'b0;
                        pend_reg <= 1'b0;
                    end else if (frame_stb && !learn_ok) begin
                        if (bad_reg) begin
                            mode_reg <= rcr_pkg::RCR_RUN;
                            pairing_active <= 1'b0;
                            pend_reg <= 1'b0;
                        end
                        bad_reg <= 1'b1;
                    end
                end
                default: mode_reg <= rcr_pkg::RCR_RUN;
            endcase
        end
    end

    // 1 ms enable divider
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_reg <= 32'h0;
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= (tick_cnt_reg == 32'(TICK_CYCLES - 1));
            tick_cnt_reg <= (tick_cnt_reg == 32'(TICK_CYCLES - 1))
                            ? 32'h0 : tick_cnt_reg + 32'h1;
        end
    end

    // reception window and long press timing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gap_cnt_reg <= 12'h000;
            hold_cnt_reg <= 12'h000;
            last_slot_reg <= '0;
            last_btn_reg <= 4'h0;
            long_press_output <= 1'b0;
        end else begin
            if (accept) begin
                gap_cnt_reg <= 12'(`RCR_GAP_TICKS);
                last_slot_reg <= hit_idx;
                last_btn_reg <= word.button;
                // a new button or transmitter restarts the hold
                if (!same_press) begin
                    hold_cnt_reg <= 12'h000;
                end
            end else if (tick_reg) begin
                gap_cnt_reg <= cnt_down(gap_cnt_reg);
                if (receiving && hold_cnt_reg != 12'(`RCR_LONG_TICKS)) begin
                    hold_cnt_reg <= hold_cnt_reg + 12'h001;
                end
            end
            // held past the long threshold, dropped with reception
            long_press_output <= receiving
                && hold_cnt_reg == 12'(`RCR_LONG_TICKS);
        end
    end

    // function, toggled and privileged outputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            func_cnt_reg <= 12'h000;
            button_function_outputs <= 3'h0;
            toggled_function_output <= 1'b0;
            privileged_output <= 1'b0;
        end else if (accept) begin
            func_cnt_reg <= 12'(`RCR_FUNC_TICKS);
            button_function_outputs <= word.button[2:0];
            privileged_output <= hit_priv;
            // flip only on a fresh activation, not while held
            if (word.button[0] && !button_function_outputs[0]) begin
                toggled_function_output <= !toggled_function_output;
            end
        end else if (tick_reg) begin
            func_cnt_reg <= cnt_down(func_cnt_reg);
            if (func_cnt_reg == 12'h001) begin
                button_function_outputs <= 3'h0;
                privileged_output <= 1'b0;
            end
        end
    end

    // valid indicator: each pulse is started by a frame, so spacing
    // tracks the transmitter's repetition rate
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rep_cnt_reg <= 12'h000;
            valid_indicator <= 1'b0;
        end else if (!receiving && !accept) begin
            rep_cnt_reg <= 12'h000; // reception over, stop pulses
            valid_indicator <= 1'b0;
        end else if (accept && rep_cnt_reg == 12'h000) begin
            rep_cnt_reg <= 12'(`RCR_VALID_PULSE_TICKS);
            valid_indicator <= 1'b1;
        end else if (tick_reg) begin
            rep_cnt_reg <= cnt_down(rep_cnt_reg);
            if (rep_cnt_reg == 12'h001) begin
                valid_indicator <= 1'b0;
            end
        end
    end

endmodule // rcr_control

`default_nettype wire

// [tb/rcr_tx_model.sv]
// Purpose: remote transmitter model driving the frame port
// Assumes: receiver rounds as agreed; inverse rounds applied here
// Notes: idle frame bus shows the inverse of the last frame
`timescale 1ns/10ps
`default_nettype none
module rcr_tx_model (
    input wire logic clk,
    output logic frame_stb,
    output rcr_pkg::rcr_frame_t frame
);
    // keyed nonlinear round function, same as the receiver's
    function automatic logic [15:0] mix(input logic [15:0] h,
                                        input logic [15:0] k);
        logic [15:0] r;
        r = {h[12:0], h[15:13]} ^ k;
        return r ^ {r[7:0] & r[15:8], r[15:8] | r[7:0]};
    endfunction
    // quiet bus at time zero
    initial begin
        frame_stb = 1'b0;
        frame = '0;
    end
    // rounds run backwards so the receiver undoes them exactly
    task automatic send(input logic [23:0] serial, input logic [63:0] key,
                        input logic [3:0] btn, input logic [15:0] seq);
        logic [15:0] a;
        logic [15:0] b;
        logic [15:0] t;
        {a, b} = {btn, serial[11:0], seq};
        for (int i = 7; i >= 0; i--) begin
            t = b;
            b = a ^ mix(b, key[16*(i%4) +: 16]);
            a = t;
        end
        @(posedge clk);
        frame_stb <= 1'b1;
        frame <= {serial, a, b};
        @(posedge clk);
        frame_stb <= 1'b0;
        frame <= ~{serial, a, b};
    endtask
endmodule // rcr_tx_model
`default_nettype wire

// [tb/rcr_control_chk.sv]
// Purpose: port-level assertions of the receiver control block
// Assumes: outputs register at the edge that takes a frame
// Notes: counters give each timer a margin of one or two ticks
`timescale 1ns/10ps
`default_nettype none
module rcr_control_chk #(
    parameter int TICK_CYCLES = 50000
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic frame_stb,
    input wire logic learn_req_n,
    input wire logic [2:0] button_function_outputs,
    input wire logic toggled_function_output,
    input wire logic long_press_output,
    input wire logic valid_indicator,
    input wire logic privileged_output,
    input wire logic pairing_active
);
    localparam int unsigned PULSE_MIN = 49 * TICK_CYCLES;
    localparam int unsigned PULSE_OFF = 52 * TICK_CYCLES;
    localparam int unsigned FUNC_OFF = 531 * TICK_CYCLES;
    localparam int unsigned GAP_OFF = 612 * TICK_CYCLES;
    localparam int unsigned LONG_MIN = 3499 * TICK_CYCLES;
    logic [31:0] gap_reg; // cycles since any frame, saturating
    logic [31:0] rx_reg; // cycles of unbroken reception
    logic [31:0] hi_reg; // cycles the indicator has stayed high
    logic [31:0] gap_next;
    logic [31:0] rx_next;
    logic [31:0] hi_next;
    assign gap_next = frame_stb ? 32'h0 : gap_reg + 32'(gap_reg < GAP_OFF);
    assign rx_next = (gap_reg < GAP_OFF) ? rx_reg + 32'h1 : 32'h0;
    assign hi_next = valid_indicator ? hi_reg + 32'h1 : 32'h0;
    // start idle: no reception is assumed before the first frame
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gap_reg <= GAP_OFF;
            rx_reg <= '0;
            hi_reg <= '0;
        end else begin
            gap_reg <= gap_next;
            rx_reg <= rx_next;
            hi_reg <= hi_next;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_valid_cause: assert property ($rose(valid_indicator) |->
        $past(frame_stb) && !$past(pairing_active))
        else $error("indicator rose without a frame");
    a_valid_stop: assert property (gap_reg >= PULSE_OFF |->
        !valid_indicator) else $error("indicator outlived its pulse");
    a_pulse_len: assert property ($fell(valid_indicator) |->
        $past(hi_reg) >= PULSE_MIN) else $error("indicator pulse short");
    a_priv_with: assert property ($rose(privileged_output) |->
        valid_indicator && $past(frame_stb))
        else $error("privileged flag without accepted frame");
    a_pair_enter: assert property ($rose(learn_req_n) &&
        $past(rst_n) && !pairing_active |-> ##1 pairing_active)
        else $error("pairing request not taken");
    a_pair_stay: assert property (pairing_active && !frame_stb |=>
        pairing_active) else $error("pairing left without a frame");
    a_func_cause: assert property ($changed(button_function_outputs)
        && button_function_outputs != 3'h0 |->
        $past(frame_stb) && !$past(pairing_active))
        else $error("function outputs moved without a frame");
    a_func_stop: assert property (gap_reg >= FUNC_OFF |->
        button_function_outputs == 3'h0 && !privileged_output)
        else $error("function outputs outlived their time");
    a_long_min: assert property ($rose(long_press_output) |->
        rx_reg >= LONG_MIN) else $error("long press came early");
    a_long_stop: assert property (gap_reg >= GAP_OFF |->
        !long_press_output) else $error("long press after reception");
    a_toggle_cause: assert property ($changed(toggled_function_output)
        |-> $past(frame_stb) && button_function_outputs[0] &&
        !$past(button_function_outputs[0]))
        else $error("latched output flipped without activation");
endmodule // rcr_control_chk
bind rcr_control rcr_control_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .clk(clk), .rst_n(rst_n), .frame_stb(frame_stb),
    .learn_req_n(learn_req_n),
    .button_function_outputs(button_function_outputs),
    .toggled_function_output(toggled_function_output),
    .long_press_output(long_press_output),
    .valid_indicator(valid_indicator),
    .privileged_output(privileged_output),
    .pairing_active(pairing_active));
`default_nettype wire

// [tb/rolling_code_receiver_control_test.sv]
// Purpose: self-checking bench with a behavioural receiver model
// Assumes: 1 ms tick shortened to 10 cycles, all timers scale
// Notes: every frame result is compared against the model
`timescale 1ns/10ps
`default_nettype none
module rolling_code_receiver_control_test;
    localparam int TC = 10;
    localparam logic [63:0] SEED = 64'h1357_9BDF_2468_ACE0; // arbitrary
    logic clk = 1'b0;
    logic rst_n, learn_req_n, prog_stb, frame_stb;
    rcr_pkg::rcr_prog_t prog;
    rcr_pkg::rcr_frame_t frame;
    logic [2:0] func_o;
    logic tog_o, long_o, valid_o, priv_o, pair_o;
    logic [7:0] obs; // all outputs side by side for one compare
    assign obs = {func_o, priv_o, valid_o, tog_o, long_o, pair_o};
    // model state: per-slot serial, key, history
    logic [23:0] m_ser [8];
    logic [63:0] m_key [8];
    logic [15:0] m_hist [8];
    bit m_used [8];
    logic [2:0] m_func;
    bit m_priv, m_tog, m_long, m_pair, m_pgood;
    int m_pbad, m_pidx, m_last;
    logic [15:0] m_pseq;
    int n_errors = 0;
    int n_compared = 0;
    always #10 clk = ~clk;
    rcr_tx_model u_rcr_tx_model (.clk(clk), .frame_stb(frame_stb),
        .frame(frame));
    rcr_control #(.TICK_CYCLES(TC), .LEARN_SEED(SEED)) u_rcr_control (
        .clk(clk), .rst_n(rst_n), .frame_stb(frame_stb), .frame(frame),
        .prog_stb(prog_stb), .prog(prog), .learn_req_n(learn_req_n),
        .button_function_outputs(func_o), .toggled_function_output(tog_o),
        .long_press_output(long_o), .valid_indicator(valid_o),
        .privileged_output(priv_o), .pairing_active(pair_o));
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        n_compared++;
        if (seen !== want) begin
            n_errors++;
            $display("BAD %0t: outputs %b expected %b", $time, seen, want);
        end
    endtask
    task automatic print_verdict();
        $display("compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // storage is written straight in, never read back
    task automatic load_slot(input int s, input logic [63:0] key);
        @(posedge clk);
        prog_stb <= 1'b1;
        prog <= {3'(s), m_ser[s], key, 16'h0000};
        @(posedge clk);
        prog_stb <= 1'b0;
        prog <= ~prog;
        m_key[s] = key;
        m_hist[s] = 16'h0000;
        m_used[s] = 1'b1;
    endtask
    // one transmission, model prediction, compare, then pulse spacing
    task automatic tx(input int s, input logic [63:0] key,
                      input logic [3:0] btn, input logic [15:0] seq);
        logic [15:0] d;
        bit ok, good;
        int j;
        d = seq - m_hist[s];
        ok = !m_pair && m_used[s] && key === m_key[s] && d != 16'h0
             && d < 16'h8000;
        good = s != 0 && key === (SEED ^ {m_ser[s], m_ser[s], m_ser[s][15:0]})
             && (!m_pgood || (s == m_pidx && seq - m_pseq < 16'h8000
             && seq != m_pseq));
        u_rcr_tx_model.send(m_ser[s], key, btn, seq);
        if (ok) begin
            m_hist[s] = seq;
            m_tog = m_tog ^ (btn[0] & ~m_func[0]);
            m_func = btn[2:0];
            m_priv = (s == 0);
        end else if (m_pair && !good) begin
            m_pbad++;
            m_pair = (m_pbad < 2);
        end else if (m_pair && m_pgood) begin
            j = 1;
            while (j < 5 && m_used[j]) j++;
            m_ser[j] = m_ser[s];
            m_key[j] = key;
            m_hist[j] = seq;
            m_used[j] = 1'b1;
            m_last = j;
            m_pair = 1'b0;
        end else if (m_pair) begin
            m_pgood = 1'b1;
            m_pidx = s;
            m_pseq = seq;
        end
        @(posedge clk);
        #1;
        check(obs, {m_func, m_priv, ok, m_tog, m_long, m_pair});
        repeat (60 * TC) @(posedge clk);
    endtask
    // let reception lapse so all timed outputs clear
    task automatic idle();
        repeat (620 * TC) @(posedge clk);
        #1;
        {m_func, m_priv, m_long} = '0;
        check(obs, {m_func, m_priv, 1'b0, m_tog, m_long, m_pair});
    endtask
    task automatic enter_pairing(input int hold);
        repeat (hold) @(posedge clk);
        learn_req_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        {m_pair, m_pgood, m_pbad} = '0;
        m_pair = 1'b1;
        check(obs, {m_func, m_priv, 1'b0, m_tog, m_long, m_pair});
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        n_errors++;
        print_verdict();
    end
    initial begin
        {rst_n, learn_req_n, prog_stb, prog} = '0;
        {m_func, m_priv, m_tog, m_long, m_pair, m_pgood} = '0;
        void'($urandom(53102));
        for (int i = 0; i < 8; i++) begin
            m_ser[i] = {16'hC35A, 8'(i)};
            m_used[i] = 1'b0;
        end
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        check(obs, 8'h00);
        for (int i = 0; i < 3; i++) load_slot(i, {$urandom, $urandom});
        enter_pairing(200 * TC);
        tx(0, SEED ^ {m_ser[0], m_ser[0], m_ser[0][15:0]},
           4'h1, 16'h1);
        tx(7, 64'h0, 4'h1, 16'h1);
        tx(0, m_key[0], 4'h5, 16'h1);
        tx(1, m_key[1], 4'h1, 16'h1);
        tx(1, m_key[1], 4'h1, 16'h1);
        tx(1, m_key[2], 4'h2, 16'h2);
        tx(2, m_key[2], 4'h3, 16'h1);
        tx(1, m_key[1], 4'h4, 16'h9000);
        idle();
        for (int i = 0; i < 6; i++) begin
            tx(1, m_key[1], 4'($urandom),
               m_hist[1] + 16'(1 + $urandom % 4));
        end
        idle();
        @(posedge clk);
        learn_req_n <= 1'b0;
        // request held low across an indicator pulse, functions all low
        tx(1, m_key[1], 4'h0, m_hist[1] + 16'h1);
        enter_pairing(1);
        m_key[7] = SEED ^ {m_ser[7], m_ser[7], m_ser[7][15:0]};
        tx(7, m_key[7], 4'h1, 16'h10);
        tx(7, m_key[7], 4'h1, 16'h11);
        tx(m_last, m_key[7], 4'h6, 16'h12);
        idle();
        for (int k = 0; k < 40; k++) begin
            m_long = (k >= 39);
            tx(1, m_key[1], 4'h2, m_hist[1] + 16'h1);
            repeat (30 * TC) @(posedge clk);
        end
        idle();
        print_verdict();
    end
endmodule // rolling_code_receiver_control_test
`default_nettype wire
